/* File: design/csr_defines.vh */
/*
  shared constants of the charger status and control register pair.
  assumes inclusion by bare name from the design files under design/.
*/
`ifndef CSR_DEFINES_VH
`define CSR_DEFINES_VH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define CSR_ADDR_W            8
`define CSR_OFS_STATE_REPORT  8'h00
`define CSR_OFS_PRIMARY_CTRL  8'h01

// ----------------------------------------------------------------------
// state report fields
// ----------------------------------------------------------------------
`define CSR_ST_CODE_HI        7
`define CSR_ST_CODE_LO        4
`define CSR_ST_BATFET         3
`define CSR_ST_RSVD           2
`define CSR_ST_STAT_SUM       1
`define CSR_ST_FAULT_SUM      0

// charge-mode codes
`define CSR_CODE_OFF          4'h0
`define CSR_CODE_WAIT         4'h1
`define CSR_CODE_SAFE         4'h2
`define CSR_CODE_PRE          4'h3
`define CSR_CODE_VOLT         4'h5
`define CSR_CODE_WEAK_WAIT    4'h8
`define CSR_CODE_WEAK_SAFE    4'h9
`define CSR_CODE_WEAK_CHG     4'hA
`define CSR_CODE_FAULT        4'hB
// boost-mode codes
`define CSR_CODE_OTG_SETUP    4'hC
`define CSR_CODE_OTG_UNCFG    4'hD
`define CSR_CODE_OTG_CFG      4'hF
`define CSR_CODE_OTG_FAULT    4'hF

// ----------------------------------------------------------------------
// primary control fields
// ----------------------------------------------------------------------
`define CSR_CT_REG_RESET      7
`define CSR_CT_CHARGE_ENABLE         6
`define CSR_CT_BOOST_EN       5
`define CSR_CT_FACTORY        4
`define CSR_CT_DERATE         3
`define CSR_CT_USB_CFG        2
`define CSR_CT_TMR_RESTART    1
`define CSR_CT_IRQ_MASK       0

`define CSR_CT_RESET_VAL      8'h55
`define CSR_CT_WRITE_MASK     8'h7F
`define CSR_CT_BOOST_CLR_MASK 8'h10
`define CSR_CT_CHG_CLR_MASK   8'h20
`define CSR_CT_TMR_CLR_MASK   8'h02
`define CSR_CT_SELF_CLR_MASK  8'h02
`define CSR_CT_PIN_SET_MASK   8'h20
`define CSR_ZERO8             8'h00

`endif

/* File: design/csr_ctl_bit.v */
/*
  one control register bit with its own default and several clear,
  set and self-clear sources.
  assumes all inputs synchronous to i_clk.
*/
`timescale 1ns/1ps

module csr_ctl_bit
#(
  parameter RESET_VAL = 1'b0
)
(
  // clock and reset
  input  wire i_clk,
  input  wire i_nrst,
  // update sources
  input  wire i_to_default,
  input  wire i_set,
  input  wire i_wr,
  input  wire i_wdata,
  input  wire i_self_clr,
  // value
  output reg  o_value
);

  reg value_next;

  // ----------------------------------------------------------------------
  // next value: default, then set, then write, then self clear
  // ----------------------------------------------------------------------
  always @*
  begin
    value_next = o_value;
    if (i_to_default)
      value_next = RESET_VAL;
    else if (i_set)
      value_next = 1'b1;
    else if (i_wr)
      value_next = i_wdata;
    else if (i_self_clr)
      value_next = 1'b0;
  end

  always @(posedge i_clk)
  begin
    if (!i_nrst)
      o_value <= RESET_VAL;
    else
      o_value <= value_next;
  end

endmodule // csr_ctl_bit

/* File: design/csr_regs.v */
/*
  status report and primary control registers of a switching battery
  charger, reached through the register port of the serial control bus.
  assumes the bus front end delivers one-cycle read and write strobes
  with address and data, and that the interrupt registers, the charge
  state machine and the power stage sit outside this block.
*/
// Overview of operation
// - state report bits 7..4 carry the charge state code
// - boost mode uses codes 1100, 1101 and upper codes in same field
// - state report bit 3 reads 1 when battery isolation switch present
// - bit 1 reads 1 when any status interrupt is flagged
// - bit 0 reads 1 when charger or boost interrupt flagged
// - writing 1 to control bit 7 restores all defaults; 0 ignored
// - control bit 6 default 1; clear halts charge or boost
// - control bit 5 requests boost; set by write or pin, cleared on charge
// - control bit 4 factory select, default 1, restored on boost entry
// - control bit 3 enables charge current derating at high temperature
// - control bit 2 default 1 selects bypass switch, 0 overcurrent guard
// - control bit 1 restarts safety timer, self clears, cleared on reset event
// - control bit 0 global interrupt mask, default 1, blocks all interrupts
// - factory mode active when factory pin equals factory select bit
// - interrupt bits clear on read, masked singly and by global mask
`timescale 1ns/1ps
`include "csr_defines.vh"

module csr_regs
#(
  parameter DATA_W = 8
)
(
  // clock and reset
  input  wire              i_clk,
  input  wire              i_nrst,
  // register port
  input  wire [7:0]        i_reg_addr,
  input  wire              i_reg_wr,
  input  wire              i_reg_rd,
  input  wire [DATA_W-1:0] i_reg_wdata,
  output reg  [DATA_W-1:0] o_reg_rdata,
  output reg               o_reg_rvalid,
  // device state in
  input  wire [3:0]        i_state_code,
  input  wire              i_batfet_present,
  input  wire              i_off_state,
  input  wire              i_boost_mode_entry,
  input  wire              i_charge_mode_entry,
  input  wire              i_timer_reset_event,
  input  wire              i_boost_pin_req,
  input  wire              i_factory_pin,
  // interrupt registers in
  input  wire [DATA_W-1:0] i_status_irq_reg,
  input  wire [DATA_W-1:0] i_charger_irq_reg_a,
  input  wire [DATA_W-1:0] i_charger_irq_reg_b,
  input  wire [DATA_W-1:0] i_boost_irq_reg,
  input  wire              i_irq_unmasked_pending,
  // controls out
  output wire              o_charge_enable,
  output wire              o_boost_enable,
  output wire              o_factory_select_bit,
  output wire              o_thermal_derate_enable,
  output wire              o_usb_port_cfg,
  output wire              o_irq_global_mask,
  output reg               o_factory_mode,
  output reg               o_timer_restart,
  output reg               o_regs_reset,
  output reg               o_irq_request
);

  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  wire ctl_hit   = (i_reg_addr == `CSR_OFS_PRIMARY_CTRL);
  wire ctl_wr    = i_reg_wr & ctl_hit;
  // status report is read only, so its writes fall through here
  wire soft_rst  = ctl_wr & i_reg_wdata[`CSR_CT_REG_RESET];
  wire all_deflt = i_off_state | soft_rst;
  wire [DATA_W-1:0] ctl_value;

  // ----------------------------------------------------------------------
  // control bits
  // ----------------------------------------------------------------------
  genvar b;
  generate
    for (b = 0; b < DATA_W; b = b + 1)
    begin : g_ctl
      localparam [DATA_W-1:0] RST  = `CSR_CT_RESET_VAL;
      localparam [DATA_W-1:0] WMSK = `CSR_CT_WRITE_MASK;
      localparam [DATA_W-1:0] BMSK = `CSR_CT_BOOST_CLR_MASK;
      localparam [DATA_W-1:0] CMSK = `CSR_CT_CHG_CLR_MASK;
      localparam [DATA_W-1:0] TMSK = `CSR_CT_TMR_CLR_MASK;
      localparam [DATA_W-1:0] SMSK = `CSR_CT_SELF_CLR_MASK;
      localparam [DATA_W-1:0] PMSK = `CSR_CT_PIN_SET_MASK;
      csr_ctl_bit
      #(
        .RESET_VAL (RST[b])
      )
      u_bit
      (
        .i_clk        (i_clk),
        // boost entry, charge entry, timer event
        .i_to_default (all_deflt
                       | (BMSK[b] & i_boost_mode_entry)
                       | (CMSK[b] & i_charge_mode_entry)
                       | (TMSK[b] & i_timer_reset_event)),
        .i_nrst       (i_nrst),
        .i_set        (PMSK[b] & i_boost_pin_req),
        .i_wr         (WMSK[b] & ctl_wr),
        .i_wdata      (i_reg_wdata[b]),
        .i_self_clr   (SMSK[b] & ctl_value[b]),
        .o_value      (ctl_value[b])
      );
    end
  endgenerate

  assign o_charge_enable         = ctl_value[`CSR_CT_CHARGE_ENABLE];
  assign o_boost_enable          = ctl_value[`CSR_CT_BOOST_EN];
  assign o_factory_select_bit    = ctl_value[`CSR_CT_FACTORY];
  assign o_thermal_derate_enable = ctl_value[`CSR_CT_DERATE];
  assign o_usb_port_cfg          = ctl_value[`CSR_CT_USB_CFG];
  assign o_irq_global_mask       = ctl_value[`CSR_CT_IRQ_MASK];

  // ----------------------------------------------------------------------
  // state report
  // ----------------------------------------------------------------------
  reg [DATA_W-1:0] status_next;
  reg [DATA_W-1:0] rdata_next;

  always @*
  begin
    status_next = `CSR_ZERO8;
    status_next[`CSR_ST_CODE_HI:`CSR_ST_CODE_LO] = i_state_code;
    status_next[`CSR_ST_BATFET]    = i_batfet_present;
    status_next[`CSR_ST_STAT_SUM]  = |i_status_irq_reg;
    status_next[`CSR_ST_FAULT_SUM] = |{i_charger_irq_reg_a,
                                       i_charger_irq_reg_b,
                                       i_boost_irq_reg};
    case (i_reg_addr)
      `CSR_OFS_STATE_REPORT : rdata_next = status_next;
      `CSR_OFS_PRIMARY_CTRL : rdata_next = ctl_value;
      default               : rdata_next = `CSR_ZERO8;
    endcase
  end

  // ----------------------------------------------------------------------
  // read data, pulses and derived levels
  // ----------------------------------------------------------------------
  always @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      o_reg_rdata     <= `CSR_ZERO8;
      o_reg_rvalid    <= 1'b0;
      o_factory_mode  <= 1'b0;
      o_timer_restart <= 1'b0;
      o_regs_reset    <= 1'b0;
      o_irq_request   <= 1'b0;
    end
    else
    begin
      o_reg_rvalid    <= i_reg_rd;
      if (i_reg_rd)
        o_reg_rdata   <= rdata_next;
      // xnor: pin and bit agree means factory mode
      o_factory_mode  <= ~(i_factory_pin ^ ctl_value[`CSR_CT_FACTORY]);
      // reg reset wins, so a write that also restarts does not pulse
      o_timer_restart <= ctl_wr & ~soft_rst
                         & i_reg_wdata[`CSR_CT_TMR_RESTART];
      o_regs_reset    <= soft_rst;
      // pending is already per-bit masked; clear-on-read lives with the flags
      o_irq_request   <= i_irq_unmasked_pending
                         & ~ctl_value[`CSR_CT_IRQ_MASK];
    end
  end

endmodule // csr_regs

/* File: tb/csr_host.sv */
/* bus master model driving the register port strobes.
   assumes the bench clock; drives only on falling edges. */
`timescale 1ns/1ps
module csr_host
(
  // clock
  input  wire       i_clk,
  // register port
  input  wire [7:0] i_rdata,
  input  wire       i_rvalid,
  output reg  [7:0] o_addr,
  output reg        o_wr,
  output reg        o_rd,
  output reg  [7:0] o_wdata
);
  // ----
  // access tasks
  // ----
  initial {o_addr, o_wr, o_rd, o_wdata} = 18'h0;
  // released lines show the inverse, never a stale copy
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(negedge i_clk) {o_addr, o_wdata, o_wr} = {a, d, 1'b1};
      @(negedge i_clk) {o_addr, o_wdata, o_wr} = {~a, ~d, 1'b0};
    end
  endtask
  task rd(input [7:0] a, output [7:0] d, output ok);
    integer n;
    begin
      @(negedge i_clk) {o_addr, o_rd} = {a, 1'b1};
      @(negedge i_clk) {o_addr, o_rd} = {~a, 1'b0};
      {ok, d} = 9'h000;
      for (n = 0; n < 3 && !ok; n = n + 1)
        if (i_rvalid === 1'b1)
          {ok, d} = {1'b1, i_rdata};
        else
          @(negedge i_clk);
    end
  endtask
endmodule // csr_host

/* File: tb/csr_regs_chk.sv */
/* assertions on the register port and control outputs.
   assumes binding to csr_regs, one clock domain. */
`timescale 1ns/1ps
module csr_regs_chk
(
  input wire       i_clk,
  input wire       i_nrst,
  input wire [7:0] i_reg_addr,
  input wire       i_reg_wr,
  input wire       i_reg_rd,
  input wire [7:0] i_reg_wdata,
  input wire [3:0] i_state_code,
  input wire       i_batfet_present,
  input wire [7:0] i_status_irq_reg,
  input wire [7:0] i_charger_irq_reg_a,
  input wire [7:0] i_charger_irq_reg_b,
  input wire [7:0] i_boost_irq_reg,
  input wire       i_irq_unmasked_pending,
  input wire       i_factory_pin,
  input wire [7:0] o_reg_rdata,
  input wire       o_reg_rvalid,
  input wire       o_charge_enable,
  input wire       o_factory_select_bit,
  input wire       o_irq_global_mask,
  input wire       o_factory_mode,
  input wire       o_timer_restart,
  input wire       o_regs_reset,
  input wire       o_irq_request
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  wire st_rd = i_reg_rd && i_reg_addr == 8'h00;
  wire ct_wr = i_reg_wr && i_reg_addr == 8'h01;
  a_read_valid: assert property (i_reg_rd |=> o_reg_rvalid)
    else $error("read gave no valid");
  a_state_code: assert property (st_rd |=> o_reg_rdata[7:3] ==
    {$past(i_state_code), $past(i_batfet_present)}) else $error("state code wrong");
  a_rsvd_zero: assert property (st_rd |=> !o_reg_rdata[2])
    else $error("reserved bit set");
  a_stat_sum: assert property (st_rd |=> o_reg_rdata[1] == |$past(i_status_irq_reg))
    else $error("status summary wrong");
  a_fault_sum: assert property (st_rd |=> o_reg_rdata[0] == (|$past(i_charger_irq_reg_a)
    || |$past(i_charger_irq_reg_b) || |$past(i_boost_irq_reg))) else $error("fault sum wrong");
  a_soft_reset: assert property (ct_wr && i_reg_wdata[7] |=>
    o_regs_reset && o_charge_enable && o_irq_global_mask) else $error("soft reset failed");
  a_timer_pulse: assert property (ct_wr && i_reg_wdata[1] && !i_reg_wdata[7] |=>
    o_timer_restart ##1 !o_timer_restart) else $error("timer restart pulse wrong");
  a_irq_gate: assert property ($past(i_nrst) |-> o_irq_request ==
    ($past(i_irq_unmasked_pending) && !$past(o_irq_global_mask))) else $error("irq gate wrong");
  a_factory_mode: assert property ($past(i_nrst) |-> o_factory_mode ==
    ($past(i_factory_pin) == $past(o_factory_select_bit))) else $error("factory mode wrong");
  c_soft_reset: cover property (o_regs_reset);
  c_irq: cover property (o_irq_request);
  c_factory: cover property (o_factory_mode);
endmodule // csr_regs_chk
bind csr_regs csr_regs_chk i_csr_regs_chk (.*);

/* File: tb/csr_regs_tb.sv */
/* self-checking bench of the status and control pair.
   assumes csr_host as bus master and the bound checker. */
`timescale 1ns/1ps
module csr_regs_tb;
  reg        i_clk = 1'b0;
  reg        i_nrst = 1'b0;
  reg  [3:0] code, c;
  reg        bat, off, bst, chg, tev, pin, fpin, pend, ok;
  reg  [7:0] sirq, irqa, irqb, birq, rv;
  wire [7:0] addr, wdata, rdata;
  wire       wr, rd_s, rvalid, fmode, trs, rrs, irq;
  wire [5:0] ctl;
  integer    mismatches = 0, compares = 0, tst = 0, k;
  localparam [47:0] CODES = 48'h0123589ABCDF;
  csr_host i_csr_host (.i_clk(i_clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_addr(addr),
    .o_wr(wr), .o_rd(rd_s), .o_wdata(wdata));
  csr_regs i_csr_regs (.i_clk(i_clk), .i_nrst(i_nrst), .i_reg_addr(addr), .i_reg_wr(wr),
    .i_reg_rd(rd_s), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
    .i_state_code(code), .i_batfet_present(bat), .i_off_state(off),
    .i_boost_mode_entry(bst), .i_charge_mode_entry(chg), .i_timer_reset_event(tev),
    .i_boost_pin_req(pin), .i_factory_pin(fpin), .i_status_irq_reg(sirq),
    .i_charger_irq_reg_a(irqa), .i_charger_irq_reg_b(irqb), .i_boost_irq_reg(birq),
    .i_irq_unmasked_pending(pend), .o_charge_enable(ctl[5]), .o_boost_enable(ctl[4]),
    .o_factory_select_bit(ctl[3]), .o_thermal_derate_enable(ctl[2]),
    .o_usb_port_cfg(ctl[1]), .o_irq_global_mask(ctl[0]), .o_factory_mode(fmode),
    .o_timer_restart(trs), .o_regs_reset(rrs), .o_irq_request(irq));
  always #5 i_clk = ~i_clk;
  // ----
  // helpers
  // ----
  task chk(input [7:0] s, input [7:0] e);
    begin
      compares = compares + 1;
      if (s !== e)
      begin
        mismatches = mismatches + 1;
        $display("BAD t=%0t seen %h exp %h", $time, s, e);
      end
    end
  endtask
  task stop_test;
    begin
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  // bounded read; a missing answer ends the run
  task rdc(input [7:0] a, input [7:0] e);
    begin
      i_csr_host.rd(a, rv, ok);
      if (!ok)
      begin
        mismatches = mismatches + 1;
        stop_test;
      end
      else
        chk(rv, e);
    end
  endtask
  task done;
    begin
      tst = tst + 1;
      $display("test %0d ends", tst);
    end
  endtask
  // ----
  // sequence
  // ----
  initial
  begin
    {code, bat, off, bst, chg, tev, pin, fpin, pend, sirq, irqa, irqb, birq} = 45'h0;
    repeat (20) @(negedge i_clk);
    i_nrst = 1'b1;
    rdc(8'h01, 8'h55);
    done;
    for (k = 0; k < 12; k = k + 1)
    begin
      c = CODES[47-4*k -: 4];
      {code, bat, sirq, irqa, irqb, birq} = {c, c[0], 2'h0, c[1], 5'h0, 3'h0, c[2], 4'h0,
        4'h0, c[3], 3'h0, c[0], 7'h0};
      rdc(8'h00, {c, c[0], 1'b0, c[1], c[2] | c[3] | c[0]});
    end
    done;
    i_csr_host.wr(8'h00, 8'hFF);
    rdc(8'h01, 8'h55);
    rdc(8'h07, 8'h00);
    done;
    i_csr_host.wr(8'h01, 8'h0A);
    chk({7'h0, trs}, 8'h01);
    rdc(8'h01, 8'h08);
    chk({2'h0, ctl}, 8'h04);
    pend = 1'b1;
    repeat (2) @(negedge i_clk);
    chk({7'h0, irq}, 8'h01);
    i_csr_host.wr(8'h01, 8'h09);
    repeat (2) @(negedge i_clk);
    chk({7'h0, irq}, 8'h00);
    chk({7'h0, fmode}, 8'h01);
    fpin = 1'b1;
    repeat (2) @(negedge i_clk);
    chk({7'h0, fmode}, 8'h00);
    done;
    @(negedge i_clk) pin = 1'b1;
    @(negedge i_clk) pin = 1'b0;
    rdc(8'h01, 8'h29);
    @(negedge i_clk) bst = 1'b1;
    @(negedge i_clk) bst = 1'b0;
    rdc(8'h01, 8'h39);
    @(negedge i_clk) chg = 1'b1;
    @(negedge i_clk) chg = 1'b0;
    rdc(8'h01, 8'h19);
    i_csr_host.wr(8'h01, 8'h80);
    chk({7'h0, rrs}, 8'h01);
    rdc(8'h01, 8'h55);
    i_csr_host.wr(8'h01, 8'h00);
    @(negedge i_clk) off = 1'b1;
    @(negedge i_clk) off = 1'b0;
    rdc(8'h01, 8'h55);
    done;
    stop_test;
  end
endmodule // csr_regs_tb
